// ---- src/mode_select_and_system_control.v ----
// mode strap decode, mode readback and system configuration registers,
// bus cycle length sequencer, standby sequencing and nmi edge detect.
// assumes strap and nmi pins are asynchronous; register port is same clock.
`timescale 1ns/10ps
`include "mode_sys_regs.vh"

module mode_select_and_system_control #(
    parameter WAKE0 = `WAKE_STATES_0,
    parameter WAKE1 = `WAKE_STATES_1,
    parameter WAKE2 = `WAKE_STATES_2,
    parameter WAKE3 = `WAKE_STATES_3,
    parameter WAKE4 = `WAKE_STATES_4,
    parameter WAKE5 = `WAKE_STATES_5
) (
    // clock and reset
    input  wire               core_clk,
    input  wire               resetn,
    // register port
    input  wire [19:0]        regAddr,
    input  wire [7:0]         regWrData,
    input  wire               regWr,
    input  wire               regRd,
    output reg  [7:0]         regRdData_q,
    // board pins
    input  wire [2:0]         modeStrapPins,
    input  wire               nmiPin,
    // mode results
    output reg  [2:0]         modeNumber_q,
    output reg                modeLegal_q,
    output reg                space16M_q,
    output reg                busWide_q,
    // bus access request
    input  wire               accReq,
    input  wire [1:0]         accKind,
    input  wire [23:0]        accAddr,
    input  wire               accPeriphWide,
    output reg                accBusy_q,
    output reg                accDone_q,
    output reg                accExternal_q,
    output reg                accWide_q,
    // power control
    input  wire               sleepExec,
    input  wire               wakeIrq,
    output reg                sleeping_q,
    output reg                standby_q,
    output reg                addrDriveEn_q,
    output reg                ctrlDriveEn_q,
    output reg                ctrlForceHigh_q,
    // configuration outputs
    output reg                userFlagEnable_q,
    output reg                nmiReq_q
);

    localparam WAKE6       = `WAKE_STATES_6;
    localparam KIND_MEM    = 2'h0;
    localparam KIND_PERIPH = 2'h1;
    localparam KIND_EXT    = 2'h2;

    localparam PWR_RUN     = 2'h0;
    localparam PWR_SLEEP   = 2'h1;
    localparam PWR_STANDBY = 2'h2;
    localparam PWR_SETTLE  = 2'h3;

    reg  [7:0]  sysCfg_q;
    reg  [7:0]  areaWidth_q;
    reg  [7:0]  areaWait_q;
    reg  [2:0]  strap1_q;
    reg  [2:0]  strap2_q;
    reg  [2:0]  strap3_q;
    reg  [2:0]  strapStable_q;
    reg  [1:0]  fill_q;
    reg         modeCaught_q;
    reg         nmi1_q;
    reg         nmi2_q;
    reg         nmi3_q;
    reg         nmiStable_q;
    reg  [1:0]  accCnt_q;
    reg  [1:0]  pwr_q;
    // the longest wait needs 19 bits; 18 would fold it to zero
    reg  [18:0] wake_q;
    reg  [18:0] wakeLen;
    reg  [1:0]  accLen;
    reg         ramHit;
    reg         accInternal;
    reg  [2:0]  modeDec;
    wire [2:0]  accArea;
    wire        running;
    wire        selMode;
    wire        selCfg;
    wire        selWidth;
    wire        selWait;

    assign selMode  = (regAddr == `OFS_MODE_READBACK);
    assign selCfg   = (regAddr == `OFS_SYS_CONFIG);
    assign selWidth = (regAddr == `OFS_AREA_WIDTH);
    assign selWait  = (regAddr == `OFS_AREA_WAIT);
    assign running  = (pwr_q == PWR_RUN);
    assign accArea  = space16M_q ? accAddr[23:21] : accAddr[19:17];

    // pin synchronisers; a change counts once stages two and three agree
    always @(posedge core_clk) begin
        if (!resetn) begin
            strap1_q      <= 3'h0;
            strap2_q      <= 3'h0;
            strap3_q      <= 3'h0;
            strapStable_q <= 3'h0;
            fill_q        <= 2'h0;
            nmi1_q        <= 1'b1;
            nmi2_q        <= 1'b1;
            nmi3_q        <= 1'b1;
            nmiStable_q   <= 1'b1;
        end else begin
            strap1_q <= modeStrapPins;
            strap2_q <= strap1_q;
            strap3_q <= strap2_q;
            if (strap2_q == strap3_q) begin
                strapStable_q <= strap3_q;
            end
            if (fill_q != 2'h3) begin
                fill_q <= fill_q + 2'h1;
            end
            nmi1_q <= nmiPin;
            nmi2_q <= nmi1_q;
            nmi3_q <= nmi2_q;
            if (nmi2_q == nmi3_q) begin
                nmiStable_q <= nmi3_q;
            end
        end
    end

    always @* begin
        modeDec = 3'h0;
        case (strapStable_q)
            3'h1: modeDec = 3'h1;
            3'h2: modeDec = 3'h2;
            3'h3: modeDec = 3'h3;
            3'h4: modeDec = 3'h4;
            default: modeDec = 3'h0;
        endcase
    end

    // mode caught once after reset release; straps are assumed frozen
    // from then on, so later pin motion is not followed
    always @(posedge core_clk) begin
        if (!resetn) begin
            modeCaught_q <= 1'b0;
            modeNumber_q <= 3'h0;
            modeLegal_q  <= 1'b0;
            space16M_q   <= 1'b0;
            areaWidth_q  <= `AREA_WIDTH_RESET;
        end else begin
            // wait until the filtered value has caught up with stage three
            if (!modeCaught_q && fill_q == 2'h3 &&
                strapStable_q == strap3_q) begin
                modeCaught_q <= 1'b1;
                modeNumber_q <= modeDec;
                modeLegal_q  <= (modeDec != 3'h0);
                space16M_q   <= modeDec[2] | (modeDec == 3'h3);
                areaWidth_q  <= (modeDec == 3'h2 || modeDec == 3'h4) ?
                                8'hff : 8'h00;
            end else if (regWr && selWidth) begin
                areaWidth_q  <= regWrData;
            end
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            busWide_q <= 1'b0;
        end else begin
            busWide_q <= |areaWidth_q;
        end
    end

    // configuration and wait registers
    always @(posedge core_clk) begin
        if (!resetn) begin
            sysCfg_q   <= `SYSCFG_RESET;
            areaWait_q <= `AREA_WAIT_RESET;
        end else begin
            if (regWr && selCfg) begin
                sysCfg_q <= regWrData;
            end
            if (regWr && selWait) begin
                areaWait_q <= regWrData;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (!resetn) begin
            regRdData_q <= 8'h00;
        end else if (regRd) begin
            if (selMode) begin
                regRdData_q <= {`MODE_FIXED_HIGH, `MODE_FIXED_LOW,
                                strapStable_q};
            end else if (selCfg) begin
                regRdData_q <= sysCfg_q;
            end else if (selWidth) begin
                regRdData_q <= areaWidth_q;
            end else if (selWait) begin
                regRdData_q <= areaWait_q;
            end else begin
                regRdData_q <= 8'h00;
            end
        end else begin
            regRdData_q <= 8'h00;
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            userFlagEnable_q <= 1'b1;
        end else begin
            userFlagEnable_q <= sysCfg_q[`BIT_USER_FLAG];
        end
    end

    // nmi edge detect on the filtered level
    always @(posedge core_clk) begin
        if (!resetn) begin
            nmiReq_q <= 1'b0;
        end else begin
            nmiReq_q <= sysCfg_q[`BIT_NMI_EDGE] ?
                        (nmi2_q == nmi3_q && nmi3_q && !nmiStable_q) :
                        (nmi2_q == nmi3_q && !nmi3_q && nmiStable_q);
        end
    end

    // access length and routing
    always @* begin
        ramHit = space16M_q ?
                 (accAddr >= `RAM_BASE_16M && accAddr <= `RAM_LAST_16M) :
                 (accAddr[19:0] >= `RAM_BASE_1M &&
                  accAddr[19:0] <= `RAM_LAST_1M);
        accInternal = 1'b0;
        accLen = `STATES_SLOW;
        case (accKind)
            KIND_MEM: begin
                accInternal = ramHit && sysCfg_q[`BIT_RAM_ENABLE];
            end
            KIND_PERIPH: begin
                accInternal = 1'b1;
            end
            default: begin
                accInternal = 1'b0;
            end
        endcase
        if (accKind == KIND_PERIPH) begin
            accLen = `STATES_SLOW;
        end else if (accInternal) begin
            accLen = `STATES_FAST;
        end else begin
            accLen = areaWait_q[accArea] ? `STATES_SLOW :
                     `STATES_FAST;
        end
    end

    // a request is taken only while idle and running; others are dropped
    always @(posedge core_clk) begin
        if (!resetn) begin
            accBusy_q     <= 1'b0;
            accDone_q     <= 1'b0;
            accCnt_q      <= 2'h0;
            accExternal_q <= 1'b0;
            accWide_q     <= 1'b0;
        end else begin
            accDone_q <= 1'b0;
            if (!accBusy_q) begin
                if (accReq && running) begin
                    accBusy_q     <= 1'b1;
                    accCnt_q      <= accLen;
                    accExternal_q <= !accInternal;
                    if (accKind == KIND_PERIPH) begin
                        accWide_q <= accPeriphWide;
                    end else if (accInternal) begin
                        accWide_q <= 1'b1;
                    end else begin
                        accWide_q <= areaWidth_q[accArea];
                    end
                end
            end else if (accCnt_q == 2'h1) begin
                accBusy_q <= 1'b0;
                accDone_q <= 1'b1;
            end else begin
                accCnt_q <= accCnt_q - 2'h1;
            end
        end
    end

    always @* begin
        case (sysCfg_q[`BIT_WAKE_HI:`BIT_WAKE_LO])
            3'h0: wakeLen = WAKE0[18:0];
            3'h1: wakeLen = WAKE1[18:0];
            3'h2: wakeLen = WAKE2[18:0];
            3'h3: wakeLen = WAKE3[18:0];
            3'h4: wakeLen = WAKE4[18:0];
            3'h6: wakeLen = WAKE6[18:0];
            // illegal code 7 falls back to the longest, safest wait
            default: wakeLen = WAKE5[18:0];
        endcase
    end

    // power sequencing
    always @(posedge core_clk) begin
        if (!resetn) begin
            pwr_q <= PWR_RUN;
            wake_q <= 19'h0;
        end else begin
            case (pwr_q)
                PWR_RUN: begin
                    if (sleepExec && !accBusy_q) begin
                        pwr_q <= sysCfg_q[`BIT_STANDBY_SEL] ?
                                 PWR_STANDBY : PWR_SLEEP;
                    end
                end
                PWR_SLEEP: begin
                    if (wakeIrq || nmiReq_q) begin
                        pwr_q <= PWR_RUN;
                    end
                end
                PWR_STANDBY: begin
                    if (wakeIrq || nmiReq_q) begin
                        pwr_q  <= PWR_SETTLE;
                        wake_q <= wakeLen - 19'h1;
                    end
                end
                default: begin
                    if (wake_q == 19'h0) begin
                        pwr_q <= PWR_RUN;
                    end else begin
                        wake_q <= wake_q - 19'h1;
                    end
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            sleeping_q      <= 1'b0;
            standby_q       <= 1'b0;
            addrDriveEn_q   <= 1'b1;
            ctrlDriveEn_q   <= 1'b1;
            ctrlForceHigh_q <= 1'b0;
        end else begin
            sleeping_q      <= (pwr_q == PWR_SLEEP);
            standby_q       <= (pwr_q == PWR_STANDBY);
            addrDriveEn_q   <= (pwr_q != PWR_STANDBY) ||
                               sysCfg_q[`BIT_BUS_DRIVE];
            ctrlDriveEn_q   <= (pwr_q != PWR_STANDBY) ||
                               sysCfg_q[`BIT_BUS_DRIVE];
            ctrlForceHigh_q <= (pwr_q == PWR_STANDBY) &&
                               sysCfg_q[`BIT_BUS_DRIVE];
        end
    end

endmodule // mode_select_and_system_control

// ---- src/mode_sys_regs.vh ----
// register offsets, field positions, reset values and state counts
// assumes an 8-bit register port with 20-bit addresses
`ifndef MODE_SYS_REGS_VH
`define MODE_SYS_REGS_VH

`define ADDR_W            20
`define OFS_MODE_READBACK 20'hee011
`define OFS_SYS_CONFIG    20'hee012
`define OFS_AREA_WIDTH    20'hee020
`define OFS_AREA_WAIT     20'hee021

`define SYSCFG_RESET      8'h09
`define AREA_WIDTH_RESET  8'h00
`define AREA_WAIT_RESET   8'hff
`define MODE_FIXED_HIGH   2'h3
`define MODE_FIXED_LOW    3'h0

`define BIT_STANDBY_SEL   7
`define BIT_WAKE_HI       6
`define BIT_WAKE_LO       4
`define BIT_USER_FLAG     3
`define BIT_NMI_EDGE      2
`define BIT_BUS_DRIVE     1
`define BIT_RAM_ENABLE    0

`define STATES_FAST       2'h2
`define STATES_SLOW       2'h3

`define WAKE_STATES_0     8192
`define WAKE_STATES_1     16384
`define WAKE_STATES_2     32768
`define WAKE_STATES_3     65536
`define WAKE_STATES_4     131072
`define WAKE_STATES_5     262144
`define WAKE_STATES_6     1024

`define RAM_BASE_1M       20'hfef20
`define RAM_LAST_1M       20'hfff1f
`define RAM_BASE_16M      24'hffef20
`define RAM_LAST_16M      24'hffff1f

`endif

// ---- verif/mode_sys_props.sv ----
// concurrent checks on the mode and system control ports
// assumes the register header macros and a single clock domain
`timescale 1ns/10ps
`include "mode_sys_regs.vh"
module mode_sys_props (
    // clock and reset
    input wire        core_clk,
    input wire        resetn,
    // register port
    input wire [19:0] regAddr,
    input wire [7:0]  regWrData,
    input wire        regWr,
    input wire        regRd,
    input wire [7:0]  regRdData_q,
    // mode and access
    input wire [2:0]  modeNumber_q,
    input wire        modeLegal_q,
    input wire        space16M_q,
    input wire        busWide_q,
    input wire        accReq,
    input wire [1:0]  accKind,
    input wire        accBusy_q,
    input wire        accDone_q,
    input wire        sleeping_q,
    input wire        standby_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    reg  cfgFresh_q;
    wire cfgHit = regAddr == `OFS_SYS_CONFIG;
    wire take   = accReq && !accBusy_q && !sleeping_q && !standby_q;
    // config still holds its reset value until the first write
    always @(posedge core_clk)
        if (!resetn)
            cfgFresh_q <= 1'b1;
        else if (regWr && cfgHit)
            cfgFresh_q <= 1'b0;
    sequence s_cfgWrite; regWr && cfgHit; endsequence
    sequence s_cfgRead; regRd && cfgHit && !regWr; endsequence
    property p_readIdle; !regRd |=> regRdData_q == 8'h00; endproperty
    property p_modeRo;
        regRd && regAddr == `OFS_MODE_READBACK |=>
            regRdData_q[7:3] == 5'b11000;
    endproperty
    property p_cfgReset;
        regRd && cfgHit && cfgFresh_q |=> regRdData_q == `SYSCFG_RESET;
    endproperty
    property p_cfgRw;
        s_cfgWrite ##1 s_cfgRead |=> regRdData_q == $past(regWrData, 2);
    endproperty
    property p_busWide;
        regWr && regAddr == `OFS_AREA_WIDTH |->
            ##2 busWide_q == (|$past(regWrData, 2));
    endproperty
    property p_cycleLen;
        take |=> accBusy_q[*2] ##1 (accDone_q or (accBusy_q ##1 accDone_q));
    endproperty
    property p_periphLen;
        take && accKind == 2'h1 |=> accBusy_q[*3] ##1 (accDone_q && !accBusy_q);
    endproperty
    property p_space;
        modeLegal_q |-> space16M_q == (modeNumber_q >= 3'h3);
    endproperty
    property p_modeRange;
        modeLegal_q |-> modeNumber_q >= 3'h1 && modeNumber_q <= 3'h4;
    endproperty
    a_readIdle: assert property (p_readIdle) else $error("stale read data");
    a_modeRo: assert property (p_modeRo)
        else $error("mode readback fixed bits wrong");
    a_cfgReset: assert property (p_cfgReset)
        else $error("config reset value wrong");
    a_cfgRw: assert property (p_cfgRw)
        else $error("config readback wrong");
    a_busWide: assert property (p_busWide)
        else $error("bus mode does not follow area width");
    a_cycleLen: assert property (p_cycleLen)
        else $error("access not two or three states");
    a_periphLen: assert property (p_periphLen)
        else $error("peripheral access not three states");
    a_space: assert property (p_space)
        else $error("address space size wrong");
    a_modeRange: assert property (p_modeRange)
        else $error("legal mode out of range");
endmodule // mode_sys_props

bind mode_select_and_system_control mode_sys_props mode_sys_props_i (
    .core_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
    .modeNumber_q, .modeLegal_q, .space16M_q, .busWide_q, .accReq, .accKind,
    .accBusy_q, .accDone_q, .sleeping_q, .standby_q);

// ---- verif/strap_board.sv ----
// board model driving the mode strap pins
// assumes the bench moves modeSel only while resetn is low
`timescale 1ns/10ps
module strap_board (
    // clock and reset
    input  wire       core_clk,
    input  wire       resetn,
    // requested mode and pins
    input  wire [2:0] modeSel,
    output reg  [2:0] modeStrapPins
);
    initial modeStrapPins = 3'h1;
    // straps move only under reset, so the chip never sees a live change
    always @(posedge core_clk)
        if (!resetn && modeSel >= 3'h1 && modeSel <= 3'h4)
            modeStrapPins <= modeSel;
endmodule // strap_board

// ---- verif/testbench.sv ----
// self-checking bench: mode decode, config registers, access lengths
// assumes the register header is on the include path
`timescale 1ns/10ps
`include "mode_sys_regs.vh"
module testbench;
    reg         core_clk, resetn, regWr, regRd, accReq, rdPend;
    reg  [19:0] regAddr;
    reg  [7:0]  regWrData, rnd;
    reg  [2:0]  modeSel;
    reg  [1:0]  accKind;
    reg  [23:0] accAddr;
    wire [7:0]  regRdData_q;
    wire [2:0]  modeStrapPins, modeNumber_q;
    wire        modeLegal_q, space16M_q, busWide_q, accBusy_q, accDone_q;
    wire        accExternal_q, accWide_q, sleeping_q, standby_q;
    integer     failCount, compares, lenSeen, m;
    logic [7:0] rdQ[$];
    logic [7:0] accQ[$];

    strap_board strap_board_i (.core_clk, .resetn, .modeSel, .modeStrapPins);
    mode_select_and_system_control mode_select_and_system_control_i (
        .core_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData_q, .modeStrapPins, .nmiPin(1'b1), .modeNumber_q,
        .modeLegal_q, .space16M_q, .busWide_q, .accReq, .accKind, .accAddr,
        .accPeriphWide(1'b0), .accBusy_q, .accDone_q, .accExternal_q,
        .accWide_q, .sleepExec(1'b0), .wakeIrq(1'b0), .sleeping_q,
        .standby_q, .addrDriveEn_q(), .ctrlDriveEn_q(), .ctrlForceHigh_q(),
        .userFlagEnable_q(), .nmiReq_q());

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic printVerdict;
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // called right after an edge, so strobes may run back to back
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        regRd   <= 1'b1;
        regAddr <= a;
        rdQ.push_back(e);
        @(posedge core_clk);
        regRd <= 1'b0;
    endtask
    // expected note: wide, external, two zero bits, state count
    task automatic acc(input logic [1:0] k, input logic [23:0] a,
                       input logic [7:0] e);
        @(posedge core_clk);
        accReq  <= 1'b1;
        accKind <= k;
        accAddr <= a;
        accQ.push_back(e);
        @(posedge core_clk);
        accReq <= 1'b0;
        for (int i = 0; i < 8 && accQ.size() != 0; i++)
            @(posedge core_clk);
    endtask
    task automatic boot(input logic [2:0] md);
        resetn  <= 1'b0;
        modeSel <= md;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (7) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (rdPend)
            check("rdData", regRdData_q, rdQ.pop_front());
        rdPend <= regRd;
    end
    always @(posedge core_clk) begin
        if (accBusy_q)
            lenSeen++;
        if (accDone_q) begin
            check("access", {accWide_q, accExternal_q, 2'b00, lenSeen[3:0]},
                  accQ.pop_front());
            lenSeen = 0;
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        failCount++;
        printVerdict;
    end
    initial begin
        {resetn, regWr, regRd, accReq, rdPend} = 5'h00;
        {regAddr, regWrData, accKind, accAddr} = 54'h0;
        modeSel = 3'h1;
        {failCount, compares, lenSeen} = 96'h0;
        void'($urandom(32'h42617e80));
        for (m = 1; m <= 4; m++) begin
            boot(m[2:0]);
            check("mode", {5'h0, modeNumber_q}, m[7:0]);
            check("space", {7'h0, space16M_q}, {7'h0, m > 2});
            check("wide", {7'h0, busWide_q}, {7'h0, !m[0]});
            rd(`OFS_MODE_READBACK, 8'hc0 | m[7:0]);
        end
        rd(`OFS_SYS_CONFIG, `SYSCFG_RESET);
        wr(`OFS_MODE_READBACK, 8'h3f);
        rd(`OFS_MODE_READBACK, 8'hc4);
        rd(20'hee013, 8'h00);
        rnd = 8'($urandom);
        wr(`OFS_SYS_CONFIG, rnd);
        rd(`OFS_SYS_CONFIG, rnd);
        wr(`OFS_SYS_CONFIG, `SYSCFG_RESET);
        wr(`OFS_AREA_WIDTH, 8'($urandom) | 8'h01);
        repeat (2) @(posedge core_clk);
        check("busWide", {7'h0, busWide_q}, 8'h01);
        wr(`OFS_AREA_WIDTH, 8'h00);
        repeat (2) @(posedge core_clk);
        check("busWide", {7'h0, busWide_q}, 8'h00);
        acc(2'h0, `RAM_BASE_16M, 8'h82);
        acc(2'h1, 24'($urandom), 8'h03);
        acc(2'h2, 24'h200000, 8'h43);
        wr(`OFS_AREA_WAIT, 8'hfd);
        acc(2'h2, 24'h200000, 8'h42);
        wr(`OFS_SYS_CONFIG, 8'h08);
        acc(2'h0, `RAM_BASE_16M, 8'h43);
        check("pending", 8'(accQ.size() + rdQ.size()), 8'h00);
        printVerdict;
    end
endmodule // testbench
